// [common/serial_cfg_pkg.sv]
`default_nettype none

package serial_cfg_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_BAUD = 8'h0C;
  localparam logic [7:0] OFF_GUARD = 8'h10;
  localparam logic [7:0] OFF_TIMEOUT = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h20;

  // ==========================================================================
  // reset values
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [15:0] GUARD_RST = 16'h0000;
  localparam logic [7:0] CHUNK_RST = 8'h00;
  localparam logic [23:0] LIMIT_RST = 24'h000000;

  // ==========================================================================
  // field positions
  localparam int BAUD_INT_LSB = 4;
  localparam int BAUD_INT_MSB = 15;
  localparam int BAUD_FRAC_MSB = 3;
  localparam int GUARD_LSB = 8;
  localparam int GUARD_MSB = 15;
  localparam int PSC_MSB = 7;
  localparam int PSC_SC_MSB = 4;
  localparam int CHUNK_LSB = 24;
  localparam int CHUNK_MSB = 31;
  localparam int LIMIT_MSB = 23;
  localparam int BAUD_USED_MSB = 15;
  localparam int GUARD_USED_MSB = 15;

  // ==========================================================================
  // command bits
  localparam int CMD_AUTOBAUD = 0;
  localparam int CMD_BREAK = 1;
  localparam int CMD_MUTE = 2;
  localparam int CMD_RX_FLUSH = 3;
  localparam int CMD_TX_FLUSH = 4;

  // ==========================================================================
  // status bits
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_MUTE = 2;
  localparam int ST_BREAK = 3;
  localparam int ST_AUTOBAUD = 4;
  localparam int ST_IDLE_GAP = 5;
  localparam int ST_AB_ARMED = 6;
  localparam int ST_BLK_LSB = 8;
  localparam int ST_BLK_MSB = 15;

  // ==========================================================================
  // divider constants
  localparam logic [8:0] IRDA_NORMAL_DIV = 9'h001;

  // ==========================================================================
  // break sequencer
  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_WAIT = 2'b01,
    BRK_SEND = 2'b10
  } brk_e;

endpackage

`default_nettype wire

// [common/idle_timer_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface idle_timer_if;
  logic tick;
  logic restart;
  logic halt;
  logic [23:0] limit;
  logic limit_wr;
  logic [23:0] wr_value;
  logic clear;
  logic [23:0] count;
  logic flag;

  modport ctrl (
    output tick, restart, halt, limit, limit_wr, wr_value, clear,
    input count, flag
  );
  modport timer (
    input tick, restart, halt, limit, limit_wr, wr_value, clear,
    output count, flag
  );
endinterface

`default_nettype wire

// [hw/idle_gap_timer.sv]
`timescale 1ns/10ps
`default_nettype none

module idle_gap_timer (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control side
  idle_timer_if.timer tmr
);

  typedef struct packed {
    logic [23:0] count;
    logic running;
    logic flag;
  } timer_s;

  timer_s s;
  timer_s next_s;

  // ==========================================================================
  // counter and flag
  always_comb begin
    next_s = s;
    if (tmr.restart) begin
      next_s.count = 24'h000000;
      next_s.running = 1'b1;
    end else if (tmr.halt) begin
      next_s.running = 1'b0;
    end else if (s.running && tmr.tick && s.count != 24'hFFFFFF) begin
      // saturate so a long gap never wraps back under the limit
      next_s.count = s.count + 24'h000001;
    end
    if (tmr.clear) begin
      next_s.flag = 1'b0;
    end
    // set wins over clear
    if (s.running && next_s.count > tmr.limit) begin
      next_s.flag = 1'b1;
    end
    if (tmr.limit_wr && s.running && tmr.wr_value <= s.count) begin
      next_s.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tmr.count = s.count;
  assign tmr.flag = s.flag;

endmodule

`default_nettype wire

// [hw/serial_baud_timeout_command_regs.sv]
// Function
// - integer divisor comes from baud divider bits 15:4.
// - fraction is bits 3:0, or bits 2:0 shifted up when oversample_select is 1.
// - guard interval sits in bits 15:8 of the prescale and guard register.
// - infrared low-power divides by the prescale value; zero is not programmed.
// - smartcard divides by twice prescale bits 4:0; upper bits stay zero.
// - block counter resets on tx not empty in smartcard, else rx off or clear.
// - idle_gap_flag sets when the gap after a character exceeds idle_gap_limit.
// - smartcard timing uses the same limit and starts at the start bit.
// - limit writes on the fly set the flag if at or below the counter.
// - tx_flush_cmd sets tx_empty_flag and discards pending transmit data.
// - rx_flush_cmd clears rx_full_flag, dropping the received data.
// - mute_enter_cmd enters mute mode and sets mute_state_flag.
// - break_send_cmd sets break_pending_flag; break goes out once transmitter idles.
// - autobaud_cmd clears autobaud_done_flag and arms measurement on next frame.
`timescale 1ns/10ps
`default_nettype none

module serial_baud_timeout_command_regs #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // mode inputs from the control registers
  input wire logic unit_on,
  input wire logic rx_on,
  input wire logic oversample_select,
  input wire logic smartcard_mode,
  input wire logic irda_mode,
  input wire logic irda_low_power,
  input wire logic clear_block_counter,
  // events from the shift engines
  input wire logic baud_tick,
  input wire logic rx_start_bit,
  input wire logic rx_char_done,
  input wire logic rx_data_read,
  input wire logic rx_wakeup,
  input wire logic tx_load,
  input wire logic tx_taken,
  input wire logic tx_idle,
  input wire logic break_stop_bit,
  input wire logic autobaud_measured,
  input wire logic idle_gap_clear,
  // configuration out
  output logic [11:0] baud_divisor_int,
  output logic [3:0] baud_divisor_frac,
  output logic [7:0] guard_interval,
  output logic [8:0] clock_divide,
  output logic [7:0] t1_chunk_size,
  output logic [23:0] idle_gap_limit,
  // flags and actions out
  output logic tx_empty_flag,
  output logic rx_full_flag,
  output logic mute_state_flag,
  output logic break_pending_flag,
  output logic autobaud_done_flag,
  output logic autobaud_armed,
  output logic idle_gap_flag,
  output logic [7:0] block_count,
  output logic block_end,
  output logic tx_discard,
  output logic rx_discard,
  output logic mute_enter,
  output logic break_start
);

  if (ADDR_W < 6 || ADDR_W > 16) begin : g_addr_w_check
    $error("ADDR_W must lie between 6 and 16");
  end

  typedef struct packed {
    logic [15:0] baud;
    logic [15:0] gp;
    logic [7:0] chunk;
    logic [23:0] limit;
    logic [31:0] rdata;
    logic [8:0] clk_div;
    logic tx_empty;
    logic rx_full;
    logic mute;
    logic brk_pend;
    logic abd_done;
    logic abd_arm;
    serial_cfg_pkg::brk_e brk;
    logic brk_again;
    logic [7:0] blk_cnt;
    logic blk_end;
    logic tx_discard;
    logic rx_discard;
    logic mute_enter;
    logic brk_start;
  } regs_s;

  localparam regs_s REGS_RST = '{
    baud: serial_cfg_pkg::BAUD_RST,
    gp: serial_cfg_pkg::GUARD_RST,
    chunk: serial_cfg_pkg::CHUNK_RST,
    limit: serial_cfg_pkg::LIMIT_RST,
    rdata: 32'h00000000,
    clk_div: 9'h000,
    tx_empty: 1'b1,
    rx_full: 1'b0,
    mute: 1'b0,
    brk_pend: 1'b0,
    abd_done: 1'b0,
    abd_arm: 1'b0,
    brk: serial_cfg_pkg::BRK_IDLE,
    brk_again: 1'b0,
    blk_cnt: 8'h00,
    blk_end: 1'b0,
    tx_discard: 1'b0,
    rx_discard: 1'b0,
    mute_enter: 1'b0,
    brk_start: 1'b0
  };

  regs_s s;
  regs_s next_s;
  logic [31:0] cmd;
  logic [31:0] status;

  idle_timer_if tif ();

  idle_gap_timer u_timer (
    .clk(clk),
    .srst(srst),
    .tmr(tif.timer)
  );

  // ==========================================================================
  // helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  function automatic logic [8:0] divide_of(input logic [15:0] gp, input logic sc,
                                           input logic ir, input logic lp);
    logic [7:0] clock_prescale;
    clock_prescale = gp[serial_cfg_pkg::PSC_MSB:0];
    if (sc) begin
      divide_of = {3'h0, clock_prescale[serial_cfg_pkg::PSC_SC_MSB:0], 1'b0};
    end else if (ir && !lp) begin
      divide_of = serial_cfg_pkg::IRDA_NORMAL_DIV;
    end else begin
      divide_of = {1'b0, clock_prescale};
    end
  endfunction

  // command pulses only exist in the write cycle, nothing is stored
  assign cmd = (wr && hit(addr, serial_cfg_pkg::OFF_CMD)) ? wdata : 32'h00000000;

  always_comb begin
    status = 32'h00000000;
    status[serial_cfg_pkg::ST_TX_EMPTY] = s.tx_empty;
    status[serial_cfg_pkg::ST_RX_FULL] = s.rx_full;
    status[serial_cfg_pkg::ST_MUTE] = s.mute;
    status[serial_cfg_pkg::ST_BREAK] = s.brk_pend;
    status[serial_cfg_pkg::ST_AUTOBAUD] = s.abd_done;
    status[serial_cfg_pkg::ST_IDLE_GAP] = tif.flag;
    status[serial_cfg_pkg::ST_AB_ARMED] = s.abd_arm;
    status[serial_cfg_pkg::ST_BLK_MSB:serial_cfg_pkg::ST_BLK_LSB] = s.blk_cnt;
  end

  // ==========================================================================
  // timer hookup
  always_comb begin
    tif.tick = baud_tick;
    tif.limit = s.limit;
    tif.clear = idle_gap_clear;
    tif.limit_wr = wr && hit(addr, serial_cfg_pkg::OFF_TIMEOUT);
    tif.wr_value = wdata[serial_cfg_pkg::LIMIT_MSB:0];
    if (smartcard_mode) begin
      // waiting times run from each start bit
      tif.restart = rx_start_bit;
      tif.halt = 1'b0;
    end else begin
      tif.restart = rx_char_done;
      tif.halt = rx_start_bit;
    end
  end

  // ==========================================================================
  // register file and command effects
  always_comb begin
    next_s = s;
    next_s.tx_discard = 1'b0;
    next_s.rx_discard = 1'b0;
    next_s.mute_enter = 1'b0;
    next_s.brk_start = 1'b0;
    next_s.blk_end = 1'b0;

    // baud and guard writes; dropped while the unit runs so live divisors never glitch
    if (wr && !unit_on && hit(addr, serial_cfg_pkg::OFF_BAUD)) begin
      next_s.baud = wdata[serial_cfg_pkg::BAUD_USED_MSB:0];
    end
    if (wr && !unit_on && hit(addr, serial_cfg_pkg::OFF_GUARD)) begin
      next_s.gp = wdata[serial_cfg_pkg::GUARD_USED_MSB:0];
    end
    if (wr && hit(addr, serial_cfg_pkg::OFF_TIMEOUT)) begin
      next_s.chunk = wdata[serial_cfg_pkg::CHUNK_MSB:serial_cfg_pkg::CHUNK_LSB];
      next_s.limit = wdata[serial_cfg_pkg::LIMIT_MSB:0];
    end
    next_s.clk_div = divide_of(next_s.gp, smartcard_mode, irda_mode, irda_low_power);

    // read data valid in the cycle after the strobe only
    next_s.rdata = 32'h00000000;
    if (rd) begin
      if (hit(addr, serial_cfg_pkg::OFF_BAUD)) begin
        next_s.rdata = {16'h0000, s.baud};
      end else if (hit(addr, serial_cfg_pkg::OFF_GUARD)) begin
        next_s.rdata = {16'h0000, s.gp};
      end else if (hit(addr, serial_cfg_pkg::OFF_TIMEOUT)) begin
        next_s.rdata = {s.chunk, s.limit};
      end else if (hit(addr, serial_cfg_pkg::OFF_STATUS)) begin
        next_s.rdata = status;
      end
    end

    // transmit empty: the clear comes first so a set in the same cycle wins
    if (tx_load) begin
      next_s.tx_empty = 1'b0;
    end
    if (tx_taken || cmd[serial_cfg_pkg::CMD_TX_FLUSH]) begin
      next_s.tx_empty = 1'b1;
    end
    next_s.tx_discard = cmd[serial_cfg_pkg::CMD_TX_FLUSH];

    // receive full
    if (rx_data_read || cmd[serial_cfg_pkg::CMD_RX_FLUSH]) begin
      next_s.rx_full = 1'b0;
    end
    if (rx_char_done) begin
      next_s.rx_full = 1'b1;
    end
    next_s.rx_discard = cmd[serial_cfg_pkg::CMD_RX_FLUSH];

    // mute
    if (rx_wakeup) begin
      next_s.mute = 1'b0;
    end
    if (cmd[serial_cfg_pkg::CMD_MUTE]) begin
      next_s.mute = 1'b1;
    end
    next_s.mute_enter = cmd[serial_cfg_pkg::CMD_MUTE];

    // autobaud: a finished measurement and a new request both win their own bit
    if (autobaud_measured) begin
      next_s.abd_arm = 1'b0;
    end
    if (cmd[serial_cfg_pkg::CMD_AUTOBAUD]) begin
      next_s.abd_done = 1'b0;
      next_s.abd_arm = 1'b1;
    end
    if (autobaud_measured) begin
      next_s.abd_done = 1'b1;
    end

    // break sequencer
    case (s.brk)
      serial_cfg_pkg::BRK_IDLE: begin
        if (cmd[serial_cfg_pkg::CMD_BREAK]) begin
          next_s.brk_pend = 1'b1;
          next_s.brk = serial_cfg_pkg::BRK_WAIT;
        end
      end
      serial_cfg_pkg::BRK_WAIT: begin
        if (tx_idle) begin
          next_s.brk_start = 1'b1;
          next_s.brk = serial_cfg_pkg::BRK_SEND;
        end
      end
      serial_cfg_pkg::BRK_SEND: begin
        if (cmd[serial_cfg_pkg::CMD_BREAK]) begin
          // a request during a break is kept for one more frame, never dropped
          next_s.brk_again = 1'b1;
        end
        if (break_stop_bit) begin
          next_s.brk_again = 1'b0;
          if (cmd[serial_cfg_pkg::CMD_BREAK] || s.brk_again) begin
            next_s.brk = serial_cfg_pkg::BRK_WAIT;
          end else begin
            next_s.brk_pend = 1'b0;
            next_s.brk = serial_cfg_pkg::BRK_IDLE;
          end
        end
      end
      default: begin
        next_s.brk = serial_cfg_pkg::BRK_IDLE;
        next_s.brk_pend = 1'b0;
        next_s.brk_again = 1'b0;
      end
    endcase

    // block length counter
    if ((smartcard_mode && !s.tx_empty) ||
        (!smartcard_mode && (!rx_on || clear_block_counter))) begin
      next_s.blk_cnt = 8'h00;
    end else if (rx_char_done) begin
      if (s.blk_cnt == s.chunk) begin
        // chunk size counts from zero, so a match is the final character
        next_s.blk_end = 1'b1;
        next_s.blk_cnt = 8'h00;
      end else begin
        next_s.blk_cnt = s.blk_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= REGS_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs
  assign rdata = s.rdata;
  assign baud_divisor_int = s.baud[serial_cfg_pkg::BAUD_INT_MSB:serial_cfg_pkg::BAUD_INT_LSB];
  assign baud_divisor_frac = oversample_select ?
                             {s.baud[serial_cfg_pkg::BAUD_FRAC_MSB-1:0], 1'b0} :
                             s.baud[serial_cfg_pkg::BAUD_FRAC_MSB:0];
  assign guard_interval = s.gp[serial_cfg_pkg::GUARD_MSB:serial_cfg_pkg::GUARD_LSB];
  assign clock_divide = s.clk_div;
  assign t1_chunk_size = s.chunk;
  assign idle_gap_limit = s.limit;
  assign tx_empty_flag = s.tx_empty;
  assign rx_full_flag = s.rx_full;
  assign mute_state_flag = s.mute;
  assign break_pending_flag = s.brk_pend;
  assign autobaud_done_flag = s.abd_done;
  assign autobaud_armed = s.abd_arm;
  assign idle_gap_flag = tif.flag;
  assign block_count = s.blk_cnt;
  assign block_end = s.blk_end;
  assign tx_discard = s.tx_discard;
  assign rx_discard = s.rx_discard;
  assign mute_enter = s.mute_enter;
  assign break_start = s.brk_start;

endmodule

`default_nettype wire

// [tb/serial_regs_assertions.sv]
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// register slice checker
module serial_regs_assertions #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // modes
  input wire logic unit_on,
  input wire logic rx_on,
  input wire logic oversample_select,
  input wire logic smartcard_mode,
  input wire logic clear_block_counter,
  // outputs watched
  input wire logic [11:0] baud_divisor_int,
  input wire logic [3:0] baud_divisor_frac,
  input wire logic [7:0] guard_interval,
  input wire logic tx_empty_flag,
  input wire logic tx_discard,
  input wire logic mute_enter,
  input wire logic mute_state_flag,
  input wire logic break_pending_flag,
  input wire logic [7:0] block_count
);
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_wr(logic [7:0] a);
    wr && addr == a && !unit_on;
  endsequence
  sequence s_cmd(int b);
    wr && addr == serial_cfg_pkg::OFF_CMD && wdata[b];
  endsequence

  a_int_field: assert property (
    s_wr(serial_cfg_pkg::OFF_BAUD) |=> baud_divisor_int == $past(wdata[15:4]))
    else $error("baud integer field mismatch");
  a_frac_field: assert property (
    s_wr(serial_cfg_pkg::OFF_BAUD) |=> baud_divisor_frac ==
      (oversample_select ? {$past(wdata[2:0]), 1'b0} : $past(wdata[3:0])))
    else $error("baud fraction mismatch");
  a_guard_field: assert property (
    s_wr(serial_cfg_pkg::OFF_GUARD) |=> guard_interval == $past(wdata[15:8]))
    else $error("guard interval mismatch");
  a_tx_flush: assert property (
    s_cmd(4) |=> tx_discard && tx_empty_flag)
    else $error("transmit flush not done");
  a_mute_cmd: assert property (
    s_cmd(2) |=> mute_enter && mute_state_flag)
    else $error("mute entry not done");
  a_break_hold: assert property (
    s_cmd(1) |=> break_pending_flag)
    else $error("break request not flagged");
  a_cmd_read_zero: assert property (
    rd && addr == serial_cfg_pkg::OFF_CMD |=> rdata == 32'h00000000)
    else $error("command register read not zero");
  a_flush_cause: assert property (
    tx_discard |-> $past(wr && addr == serial_cfg_pkg::OFF_CMD && wdata[4]))
    else $error("discard pulse without command");
  a_block_clear: assert property (
    (smartcard_mode ? !tx_empty_flag : (!rx_on || clear_block_counter))
      |=> block_count == 8'h00)
    else $error("block counter not cleared");
endmodule

bind serial_baud_timeout_command_regs serial_regs_assertions #(
  .ADDR_W(ADDR_W)
) u_serial_regs_assertions (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .unit_on(unit_on), .rx_on(rx_on),
  .oversample_select(oversample_select), .smartcard_mode(smartcard_mode),
  .clear_block_counter(clear_block_counter),
  .baud_divisor_int(baud_divisor_int), .baud_divisor_frac(baud_divisor_frac),
  .guard_interval(guard_interval), .tx_empty_flag(tx_empty_flag),
  .tx_discard(tx_discard), .mute_enter(mute_enter),
  .mute_state_flag(mute_state_flag), .break_pending_flag(break_pending_flag),
  .block_count(block_count)
);

`default_nettype wire

// [tb/serial_peer_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// line-side peer: events the shift engines report
module serial_peer_model (
  // clock
  input wire logic clk,
  // one-cycle events toward the block
  output var logic [9:0] ev
);
  initial ev = 10'h000;

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask

  // a slow peer: one idle cycle between baud clocks
  task automatic ticks(input int n);
    repeat (n) pulse(0);
  endtask
endmodule

`default_nettype wire

// [tb/serial_baud_timeout_command_regs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module serial_baud_timeout_command_regs_tb_top;
  logic clk = 1'b0;
  logic srst, wr, rd, unit_on, rx_on, oversample_select, smartcard_mode;
  logic irda_mode, irda_low_power, clear_block_counter, tx_idle;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  wire [9:0] ev;
  logic [11:0] baud_divisor_int;
  logic [3:0] baud_divisor_frac;
  logic [7:0] guard_interval, t1_chunk_size, block_count;
  logic [8:0] clock_divide;
  logic [23:0] idle_gap_limit;
  logic tx_empty_flag, rx_full_flag, mute_state_flag, break_pending_flag;
  logic autobaud_done_flag, autobaud_armed, idle_gap_flag, block_end;
  logic tx_discard, rx_discard, mute_enter, break_start;
  int err_total = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  serial_peer_model u_serial_peer_model (.clk(clk), .ev(ev));

  serial_baud_timeout_command_regs u_serial_baud_timeout_command_regs (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .unit_on(unit_on), .rx_on(rx_on), .oversample_select(oversample_select),
    .smartcard_mode(smartcard_mode), .irda_mode(irda_mode), .irda_low_power(irda_low_power),
    .clear_block_counter(clear_block_counter), .baud_tick(ev[0]), .rx_start_bit(ev[1]),
    .rx_char_done(ev[2]), .rx_data_read(ev[3]), .rx_wakeup(ev[4]),
    .tx_load(ev[5]), .tx_taken(ev[6]), .tx_idle(tx_idle), .break_stop_bit(ev[7]),
    .autobaud_measured(ev[8]), .idle_gap_clear(ev[9]),
    .baud_divisor_int(baud_divisor_int), .baud_divisor_frac(baud_divisor_frac),
    .guard_interval(guard_interval), .clock_divide(clock_divide),
    .t1_chunk_size(t1_chunk_size), .idle_gap_limit(idle_gap_limit),
    .tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag),
    .mute_state_flag(mute_state_flag), .break_pending_flag(break_pending_flag),
    .autobaud_done_flag(autobaud_done_flag), .autobaud_armed(autobaud_armed),
    .idle_gap_flag(idle_gap_flag), .block_count(block_count), .block_end(block_end),
    .tx_discard(tx_discard), .rx_discard(rx_discard), .mute_enter(mute_enter),
    .break_start(break_start)
  );

  // ============================================================
  // shared tasks
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // clock_divide is registered, so give it two edges
  task automatic set_mode(input logic sc, input logic ir, input logic lp);
    @(posedge clk);
    smartcard_mode <= sc;
    irda_mode <= ir;
    irda_low_power <= lp;
    cyc(2);
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset;
    chk("tx_empty_rst", 1, tx_empty_flag);
    for (int i = 0; i < 4; i++) begin
      rd_chk("reg_rst", 8'h0C + 8'(4 * i), 0);
    end
    rd_chk("unmapped", 8'h08, 0);
  endtask

  task automatic t_baud;
    wr_reg(8'h0C, 32'hFFFFABCD);
    chk("div_int", 12'hABC, baud_divisor_int);
    chk("div_frac", 4'hD, baud_divisor_frac);
    rd_chk("baud_rd", 8'h0C, 32'h0000ABCD);
    @(posedge clk);
    oversample_select <= 1'b1;
    wr_reg(8'h0C, 32'h00001235);
    chk("frac_os", 4'hA, baud_divisor_frac);
    @(posedge clk);
    unit_on <= 1'b1;
    wr_reg(8'h0C, 32'h00000000);
    chk("baud_locked", 12'h123, baud_divisor_int);
    wr_reg(8'h10, 32'h0000FFFF);
    chk("gp_locked", 8'h00, guard_interval);
    @(posedge clk);
    unit_on <= 1'b0;
  endtask

  task automatic t_psc;
    wr_reg(8'h10, 32'h00005A1F);
    chk("guard", 8'h5A, guard_interval);
    rd_chk("gp_rd", 8'h10, 32'h00005A1F);
    set_mode(1, 0, 0);
    chk("div_sc", 9'h03E, clock_divide);
    set_mode(0, 1, 0);
    chk("div_ir", 9'h001, clock_divide);
    set_mode(0, 1, 1);
    chk("div_lp", 9'h01F, clock_divide);
    set_mode(0, 0, 0);
  endtask

  task automatic t_gap;
    wr_reg(8'h14, 32'h03000002);
    rd_chk("rt_rd", 8'h14, 32'h03000002);
    chk("chunk_out", 8'h03, t1_chunk_size);
    chk("limit_out", 24'h000002, idle_gap_limit);
    u_serial_peer_model.pulse(2);
    u_serial_peer_model.ticks(2);
    cyc(2);
    chk("gap_early", 0, idle_gap_flag);
    u_serial_peer_model.ticks(1);
    cyc(2);
    chk("gap_set", 1, idle_gap_flag);
    wr_reg(8'h14, 32'h03000010);
    u_serial_peer_model.pulse(2);
    u_serial_peer_model.pulse(9);
    u_serial_peer_model.ticks(3);
    wr_reg(8'h14, 32'h03000004);
    cyc(1);
    chk("fly_above", 0, idle_gap_flag);
    wr_reg(8'h14, 32'h03000003);
    cyc(1);
    chk("fly_equal", 1, idle_gap_flag);
    wr_reg(8'h14, 32'h03000002);
    set_mode(1, 0, 0);
    u_serial_peer_model.pulse(1);
    u_serial_peer_model.pulse(9);
    u_serial_peer_model.ticks(2);
    cyc(2);
    chk("sc_early", 0, idle_gap_flag);
    u_serial_peer_model.ticks(1);
    cyc(2);
    chk("sc_set", 1, idle_gap_flag);
    set_mode(0, 0, 0);
    u_serial_peer_model.pulse(2);
    u_serial_peer_model.pulse(9);
    u_serial_peer_model.pulse(1);
    u_serial_peer_model.ticks(4);
    cyc(2);
    chk("halted", 0, idle_gap_flag);
  endtask

  task automatic t_block;
    @(posedge clk);
    rx_on <= 1'b1;
    repeat (3) u_serial_peer_model.pulse(2);
    #1;
    chk("blk_cnt", 3, block_count);
    u_serial_peer_model.pulse(2);
    #1;
    chk("blk_end", 1, block_end);
    chk("blk_wrap", 0, block_count);
    u_serial_peer_model.pulse(2);
    @(posedge clk);
    clear_block_counter <= 1'b1;
    @(posedge clk);
    clear_block_counter <= 1'b0;
    #1;
    chk("blk_clr", 0, block_count);
    u_serial_peer_model.pulse(2);
    @(posedge clk);
    rx_on <= 1'b0;
    cyc(2);
    chk("blk_rx_off", 0, block_count);
    set_mode(1, 0, 0);
    u_serial_peer_model.pulse(2);
    u_serial_peer_model.pulse(5);
    cyc(1);
    chk("blk_sc_tx", 0, block_count);
    u_serial_peer_model.pulse(6);
    set_mode(0, 0, 0);
  endtask

  task automatic t_cmd;
    logic seen;
    seen = 1'b0;
    u_serial_peer_model.pulse(5);
    #1;
    chk("tx_loaded", 0, tx_empty_flag);
    wr_reg(8'h18, 32'h00000010);
    chk("tx_flush", 2'b11, {tx_discard, tx_empty_flag});
    cyc(1);
    chk("one_pulse", 0, tx_discard);
    u_serial_peer_model.pulse(2);
    wr_reg(8'h18, 32'h00000008);
    chk("rx_flush", 2'b10, {rx_discard, rx_full_flag});
    wr_reg(8'h18, 32'h00000004);
    chk("mute", 2'b11, {mute_enter, mute_state_flag});
    u_serial_peer_model.pulse(4);
    wr_reg(8'h18, 32'h00000002);
    cyc(4);
    chk("brk_wait", 2'b10, {break_pending_flag, break_start});
    @(posedge clk);
    tx_idle <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      seen = seen | (break_start === 1'b1);
    end
    chk("brk_sent", 1, seen);
    wr_reg(8'h18, 32'h00000002);
    u_serial_peer_model.pulse(7);
    cyc(1);
    chk("brk_again", 2'b11, {break_pending_flag, break_start});
    u_serial_peer_model.pulse(7);
    cyc(1);
    chk("brk_done", 0, break_pending_flag);
    @(posedge clk);
    tx_idle <= 1'b0;
    u_serial_peer_model.pulse(8);
    #1;
    chk("ab_done", 1, autobaud_done_flag);
    wr_reg(8'h18, 32'h00000001);
    chk("ab_cmd", 2'b01, {autobaud_done_flag, autobaud_armed});
    wr_reg(8'h18, 32'h00000000);
    cyc(1);
    chk("zero_wr", 4'b0001,
        {mute_state_flag, break_pending_flag, tx_discard, autobaud_armed});
    rd_chk("cmd_rd", 8'h18, 0);
    rd_chk("status_rd", 8'h20, 32'h00000041);
  endtask

  // ============================================================
  // main sequence and watchdog
  initial begin
    {addr, wdata, wr, rd, unit_on, rx_on, oversample_select} = '0;
    {smartcard_mode, irda_mode, irda_low_power, clear_block_counter} = '0;
    tx_idle = 1'b0;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_baud;
    t_psc;
    t_gap;
    t_block;
    t_cmd;
    close_out;
  end

  // whole run is well under a thousand cycles
  initial begin
    #20000;
    err_total++;
    close_out;
  end
endmodule

`default_nettype wire
